// ### rtl/hp_host_port.sv
// Host processor port with internal register map and user-logic access bridge.
`timescale 1ns/1ps
`include "hp_params.svh"

// Functional notes
// - All host registers are eight bits wide.
// - Control one and two are read/write.
// - Scratchpad stores writes, no side effects.
// - Status is read-only, writes ignored.
// - Offset four: config bytes in, readback out.
// - Readback address low and high bytes.
// - Identity code as four bytes, LSB first.
// - Direction polarity depends on bus style.
// - Five-bit address, eight-bit bidirectional data.
// - Open-drain ack plus burst inhibit.
// - Open-drain active-low host interrupt.
// - Muxed address latched on falling edge.
// - Byte lanes act as address bits one, zero.
// - Muxed ack drives ready/recover low.
// - Four-bit user address output.
// - User direction high means host read.
// - User begin marks each user transaction.
// - User interrupt request forwarded to host.
// - Eight-bit user write and read buses.
// - Address bit four selects user space.
// - Wait states until user done returns.
// - Host acknowledge low exactly one cycle.
module hp_host_port
  import hp_pkg::*;
#(
  parameter logic [31:0] ID_CODE = `HP_ID_DEFAULT
) (
  input wire logic host_bus_clock_i,
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic bus_style_mux_i,
  input wire logic select_low_in_n_i,
  input wire logic select_high_in_i,
  input wire logic host_dir_i,
  input wire logic transfer_begin_n_i,
  input wire logic addr_latch_i,
  input wire logic addr_data_strobe_n_i,
  input wire logic byte_lane0_addr_i,
  input wire logic byte_lane1_addr_i,
  input wire logic [4:0] host_addr_i,
  input wire logic [7:0] host_data_i,
  output logic [7:0] host_data_o,
  output logic host_data_oe_o,
  output logic transfer_ack_out_n_o,
  output logic transfer_ack_out_oe_o,
  output logic burst_inhibit_out_n_o,
  input wire logic ready_recover_line_n_i,
  output logic ready_recover_line_n_o,
  output logic ready_recover_line_oe_o,
  output logic host_interrupt_out_n_o,
  output logic host_interrupt_out_oe_o,
  output logic [7:0] control_one_o,
  output logic [7:0] control_two_o,
  output logic [15:0] readback_addr_o,
  output logic config_byte_valid_o,
  output logic [7:0] config_byte_o,
  output logic readback_take_o,
  input wire logic [7:0] readback_byte_i,
  input wire hp_status_in_t status_i,
  output logic [3:0] logic_address_o,
  output logic logic_direction_o,
  output logic logic_begin_o,
  input wire logic logic_done_i,
  input wire logic logic_interrupt_req_n_i,
  output logic [7:0] logic_write_bus_o,
  input wire logic [7:0] logic_read_bus_i,
  output logic global_set_reset_o
);

  hp_host_state_t h;
  hp_host_state_t next_h;
  hp_sys_state_t s;
  hp_sys_state_t next_s;
  logic [4:0] ale_addr;
  logic selected;
  logic start;
  logic [4:0] start_addr;
  logic start_rd;
  logic [7:0] rd_val;
  logic [7:0] status_byte;
  logic [7:0] id_byte [4];

  //////////////////////////////////////////////////////////////////////////////
  // Identity code split into its four bytes, least significant first.
  for (genvar g = 0; g < 4; g++) begin : g_id_byte
    assign id_byte[g] = ID_CODE[8 * g +: 8];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Multiplexed-style address capture on the falling edge while the latch strobe is high.
  always_ff @(negedge host_bus_clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ale_addr <= 5'h00;
    end else if (addr_latch_i) begin
      ale_addr <= host_data_i[4:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Host-clock domain: decode, register map and acknowledge.
  always_comb begin
    selected = !select_low_in_n_i && select_high_in_i;
    start = selected && (bus_style_mux_i ? !addr_data_strobe_n_i : !transfer_begin_n_i);
    start_addr = bus_style_mux_i ? {ale_addr[4:2], byte_lane1_addr_i, byte_lane0_addr_i} : host_addr_i;
    start_rd = bus_style_mux_i ? !host_dir_i : host_dir_i;
    status_byte = 8'h00;
    status_byte[`HP_ST_DATA_READY] = status_i.data_ready;
    status_byte[`HP_ST_IRQ_PENDING] = h.irq_s2;
    status_byte[`HP_ST_ERROR_HI:`HP_ST_ERROR_LO] = status_i.error;
    status_byte[`HP_ST_INIT] = status_i.init;
    status_byte[`HP_ST_DONE] = status_i.done;
    unique case (h.addr[3:0])
      `HP_OFS_CONTROL_ONE: rd_val = h.regs.ctrl_one;
      `HP_OFS_CONTROL_TWO: rd_val = h.regs.ctrl_two;
      `HP_OFS_SCRATCHPAD: rd_val = h.regs.scratch;
      `HP_OFS_PORT_STATUS: rd_val = status_byte;
      `HP_OFS_CONFIG_DATA: rd_val = readback_byte_i;
      `HP_OFS_IDENTITY0: rd_val = id_byte[0];
      `HP_OFS_IDENTITY1: rd_val = id_byte[1];
      `HP_OFS_IDENTITY2: rd_val = id_byte[2];
      `HP_OFS_IDENTITY3: rd_val = id_byte[3];
      default: rd_val = 8'h00;
    endcase

    next_h = h;
    next_h.irq_s1 = !logic_interrupt_req_n_i;
    next_h.irq_s2 = h.irq_s1;
    next_h.irq_oe = h.irq_s2;
    next_h.ack_s1 = s.ack_tgl;
    next_h.ack_s2 = h.ack_s1;
    next_h.cfg_wr = 1'b0;
    next_h.rb_rd = 1'b0;
    unique case (h.state)
      HP_IDLE: begin
        if (start) begin
          next_h.addr = start_addr;
          next_h.rd = start_rd;
          next_h.state = HP_XFER;
        end
      end
      HP_XFER: begin
        // Write data is valid on the bus in this cycle, one edge after the start.
        if (h.addr[`HP_ADDR_USER_BIT]) begin
          next_h.req.addr = h.addr[3:0];
          next_h.req.rd = h.rd;
          next_h.req.wdata = host_data_i;
          next_h.req_tgl = !h.req_tgl;
          next_h.state = HP_USER;
        end else begin
          if (h.rd) begin
            next_h.data_out = rd_val;
            next_h.data_oe = 1'b1;
            next_h.rb_rd = (h.addr[3:0] == `HP_OFS_CONFIG_DATA);
          end else begin
            unique case (h.addr[3:0])
              `HP_OFS_CONTROL_ONE: next_h.regs.ctrl_one = host_data_i;
              `HP_OFS_CONTROL_TWO: next_h.regs.ctrl_two = host_data_i;
              `HP_OFS_SCRATCHPAD: next_h.regs.scratch = host_data_i;
              `HP_OFS_CONFIG_DATA: begin
                next_h.cfg_wr = 1'b1;
                next_h.cfg_byte = host_data_i;
              end
              `HP_OFS_RB_ADDR_LOW: next_h.regs.rb_low = host_data_i;
              `HP_OFS_RB_ADDR_HIGH: next_h.regs.rb_high = host_data_i;
              default: next_h.regs = h.regs;
            endcase
          end
          next_h.ack_oe = !bus_style_mux_i;
          next_h.burst_inhibit_n = bus_style_mux_i;
          next_h.rdy_oe = bus_style_mux_i;
          next_h.state = HP_ACK;
        end
      end
      HP_USER: begin
        // The host bus is held in wait states until the user side reports done.
        if (h.ack_s2 != h.ack_seen) begin
          next_h.ack_seen = h.ack_s2;
          if (h.rd) begin
            next_h.data_out = s.rdata;
            next_h.data_oe = 1'b1;
          end
          next_h.ack_oe = !bus_style_mux_i;
          next_h.burst_inhibit_n = bus_style_mux_i;
          next_h.rdy_oe = bus_style_mux_i;
          next_h.state = HP_ACK;
        end
      end
      HP_ACK: begin
        next_h.ack_oe = 1'b0;
        next_h.burst_inhibit_n = 1'b1;
        next_h.rdy_oe = 1'b0;
        next_h.data_oe = 1'b0;
        next_h.state = HP_IDLE;
      end
    endcase
  end

  always_ff @(posedge host_bus_clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      h <= '{state: HP_IDLE, addr: 5'h00, rd: 1'b0,
             regs: '{`HP_REG_RESET, `HP_REG_RESET, `HP_REG_RESET, `HP_REG_RESET, `HP_REG_RESET},
             data_out: 8'h00, data_oe: 1'b0, ack_oe: 1'b0, burst_inhibit_n: 1'b1, rdy_oe: 1'b0,
             irq_s1: 1'b0, irq_s2: 1'b0, irq_oe: 1'b0, cfg_wr: 1'b0, cfg_byte: 8'h00, rb_rd: 1'b0,
             req_tgl: 1'b0, req: '{4'h0, 1'b0, 8'h00}, ack_s1: 1'b0, ack_s2: 1'b0, ack_seen: 1'b0};
    end else begin
      h <= next_h;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // System-clock domain: user-logic handshake. The request word is held stable by the
  // host side from its toggle until the returning toggle, so it is sampled without a synchroniser.
  always_comb begin
    next_s = s;
    next_s.req_s1 = h.req_tgl;
    next_s.req_s2 = s.req_s1;
    next_s.gsr = 1'b0;
    if (!s.busy && (s.req_s2 != s.req_seen)) begin
      next_s.req_seen = s.req_s2;
      next_s.req = h.req;
      next_s.busy = 1'b1;
      next_s.begin_q = 1'b1;
    end else if (s.busy && logic_done_i) begin
      next_s.rdata = logic_read_bus_i;
      next_s.begin_q = 1'b0;
      next_s.busy = 1'b0;
      next_s.ack_tgl = !s.ack_tgl;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '{req_s1: 1'b0, req_s2: 1'b0, req_seen: 1'b0, busy: 1'b0, begin_q: 1'b0,
             req: '{4'h0, 1'b0, 8'h00}, rdata: 8'h00, ack_tgl: 1'b0, gsr: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin and user outputs, each taken from a flip-flop.
  always_comb begin
    host_data_o = h.data_out;
    host_data_oe_o = h.data_oe;
    transfer_ack_out_n_o = 1'b0 & h.ack_oe;
    transfer_ack_out_oe_o = h.ack_oe;
    burst_inhibit_out_n_o = h.burst_inhibit_n;
    ready_recover_line_n_o = 1'b0 & h.rdy_oe;
    ready_recover_line_oe_o = h.rdy_oe;
    host_interrupt_out_n_o = 1'b0 & h.irq_oe;
    host_interrupt_out_oe_o = h.irq_oe;
    control_one_o = h.regs.ctrl_one;
    control_two_o = h.regs.ctrl_two;
    readback_addr_o = {h.regs.rb_high, h.regs.rb_low};
    config_byte_valid_o = h.cfg_wr;
    config_byte_o = h.cfg_byte;
    readback_take_o = h.rb_rd;
    logic_address_o = s.req.addr;
    logic_direction_o = s.req.rd;
    logic_begin_o = s.begin_q;
    logic_write_bus_o = s.req.wdata;
    global_set_reset_o = s.gsr;
  end

endmodule // hp_host_port

// ### pkg/hp_params.svh
// Register offsets, status field positions and reset values of the host port.
`ifndef HP_PARAMS_SVH
`define HP_PARAMS_SVH

`define HP_OFS_CONTROL_ONE 4'h0
`define HP_OFS_CONTROL_TWO 4'h1
`define HP_OFS_SCRATCHPAD 4'h2
`define HP_OFS_PORT_STATUS 4'h3
`define HP_OFS_CONFIG_DATA 4'h4
`define HP_OFS_RB_ADDR_LOW 4'h5
`define HP_OFS_RB_ADDR_HIGH 4'h6
`define HP_OFS_IDENTITY0 4'h7
`define HP_OFS_IDENTITY1 4'h8
`define HP_OFS_IDENTITY2 4'h9
`define HP_OFS_IDENTITY3 4'ha

`define HP_ADDR_USER_BIT 4
`define HP_ST_DATA_READY 0
`define HP_ST_IRQ_PENDING 1
`define HP_ST_ERROR_LO 2
`define HP_ST_ERROR_HI 3
`define HP_ST_INIT 4
`define HP_ST_DONE 5

`define HP_REG_RESET 8'h00
`define HP_ID_DEFAULT 32'h0000_0001

`endif

// ### pkg/hp_pkg.sv
// Types shared by the host port design.
package hp_pkg;

  typedef enum logic [3:0] {
    HP_IDLE = 4'b0001,
    HP_XFER = 4'b0010,
    HP_USER = 4'b0100,
    HP_ACK = 4'b1000
  } hp_state_t;

  typedef struct packed {
    logic [7:0] ctrl_one;
    logic [7:0] ctrl_two;
    logic [7:0] scratch;
    logic [7:0] rb_low;
    logic [7:0] rb_high;
  } hp_regs_t;

  typedef struct packed {
    logic data_ready;
    logic [1:0] error;
    logic init;
    logic done;
  } hp_status_in_t;

  typedef struct packed {
    logic [3:0] addr;
    logic rd;
    logic [7:0] wdata;
  } hp_user_req_t;

  typedef struct packed {
    hp_state_t state;
    logic [4:0] addr;
    logic rd;
    hp_regs_t regs;
    logic [7:0] data_out;
    logic data_oe;
    logic ack_oe;
    logic burst_inhibit_n;
    logic rdy_oe;
    logic irq_s1;
    logic irq_s2;
    logic irq_oe;
    logic cfg_wr;
    logic [7:0] cfg_byte;
    logic rb_rd;
    logic req_tgl;
    hp_user_req_t req;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
  } hp_host_state_t;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic busy;
    logic begin_q;
    hp_user_req_t req;
    logic [7:0] rdata;
    logic ack_tgl;
    logic gsr;
  } hp_sys_state_t;

endpackage

// ### bench/hp_user_model.sv
// Behavioural user logic behind the host port.
`timescale 1ns/1ps
module hp_user_model (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] lat_i,
  input wire logic begin_i,
  input wire logic [3:0] addr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic done_o,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [16];
  logic [3:0] cnt;
  ////////////////////////////////
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_o <= 1'b0;
      cnt <= 4'h0;
      rdata_o <= 8'h5a;
    end else if (done_o) begin
      done_o <= 1'b0;
      rdata_o <= ~rdata_o; // Data is not held once the handshake is over.
    end else if (begin_i && cnt != lat_i) begin
      cnt <= cnt + 4'h1;
    end else if (begin_i) begin
      done_o <= 1'b1;
      cnt <= 4'h0;
      rdata_o <= rd_i ? mem[addr_i] : ~rdata_o;
      if (!rd_i) mem[addr_i] <= wdata_i;
    end
  end
endmodule // hp_user_model

// ### bench/hp_host_port_checker.sv
// Assertions on the host port pins.
`timescale 1ns/1ps
module hp_host_port_checker (
  input wire logic host_bus_clock_i,
  input wire logic rstn_i,
  input wire logic bus_style_mux_i,
  input wire logic select_low_in_n_i,
  input wire logic select_high_in_i,
  input wire logic transfer_begin_n_i,
  input wire logic [4:0] host_addr_i,
  input wire logic transfer_ack_out_oe_o,
  input wire logic burst_inhibit_out_n_o,
  input wire logic ready_recover_line_oe_o,
  input wire logic host_interrupt_out_oe_o,
  input wire logic logic_interrupt_req_n_i,
  input wire logic logic_begin_o
);
  default clocking cb @(posedge host_bus_clock_i);
  endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////
  a_ack_single: assert property (transfer_ack_out_oe_o |=> !transfer_ack_out_oe_o)
    else $error("ack too long");
  a_ready_single: assert property (ready_recover_line_oe_o |=> !ready_recover_line_oe_o)
    else $error("ready too long");
  a_burst_ack: assert property (transfer_ack_out_oe_o == !burst_inhibit_out_n_o)
    else $error("burst inhibit");
  a_ack_style: assert property (ready_recover_line_oe_o |-> bus_style_mux_i && !transfer_ack_out_oe_o)
    else $error("ack style");
  a_sep_latency: assert property (!bus_style_mux_i && !select_low_in_n_i && select_high_in_i
    && !transfer_begin_n_i && !host_addr_i[4] |-> ##[2:4] transfer_ack_out_oe_o) else $error("no ack");
  // Host ack may only follow the end of the user handshake.
  a_user_wait: assert property (logic_begin_o |-> !transfer_ack_out_oe_o && !ready_recover_line_oe_o)
    else $error("early ack");
  a_irq_raise: assert property (!logic_interrupt_req_n_i [*4] |=> host_interrupt_out_oe_o)
    else $error("irq missing");
  a_irq_drop: assert property (logic_interrupt_req_n_i [*4] |=> !host_interrupt_out_oe_o)
    else $error("irq stuck");
endmodule // hp_host_port_checker

// ### bench/hp_host_port_tb.sv
// Bench for the host port.
`timescale 1ns/1ps
module hp_host_port_tb;
  import hp_pkg::*;
  localparam logic [31:0] ID = 32'h5a3c_9613; // Arbitrary value.
  logic host_bus_clock_i = 1'b0, sys_clk_i = 1'b0, rstn_i = 1'b0, bus_style_mux_i = 1'b0;
  logic select_low_in_n_i = 1'b1, select_high_in_i = 1'b0, host_dir_i = 1'b0, transfer_begin_n_i = 1'b1;
  logic addr_latch_i = 1'b0, addr_data_strobe_n_i = 1'b1, byte_lane0_addr_i = 1'b0, byte_lane1_addr_i = 1'b0;
  logic logic_interrupt_req_n_i = 1'b1;
  logic [4:0] host_addr_i = 5'h00;
  logic [7:0] host_data_i = 8'h00, readback_byte_i = 8'h6e;
  logic [3:0] lat = 4'h0;
  hp_status_in_t status_i = '{1'b1, 2'b10, 1'b1, 1'b0};
  logic host_data_oe_o, transfer_ack_out_n_o, transfer_ack_out_oe_o, burst_inhibit_out_n_o;
  logic ready_recover_line_n_o, ready_recover_line_oe_o, host_interrupt_out_n_o, host_interrupt_out_oe_o;
  logic config_byte_valid_o, readback_take_o, logic_direction_o, logic_begin_o, logic_done_i, global_set_reset_o;
  logic [7:0] host_data_o, control_one_o, control_two_o, config_byte_o, logic_write_bus_o, logic_read_bus_i;
  logic [15:0] readback_addr_o;
  logic [3:0] logic_address_o;
  wire ready_recover_line_n_i = !(ready_recover_line_oe_o && !ready_recover_line_n_o);
  int n_errors = 0, tests_run = 0, cyc = 0;
  hp_host_port #(.ID_CODE(ID)) dut (.*);
  hp_user_model um (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .lat_i(lat), .begin_i(logic_begin_o),
    .addr_i(logic_address_o), .rd_i(logic_direction_o), .wdata_i(logic_write_bus_o),
    .done_o(logic_done_i), .rdata_o(logic_read_bus_i));
  ////////////////////////////////
  task automatic complete_run;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] e, input logic [15:0] s, input string n);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [7:0] wv(int i, logic s);
    return 8'(8'h91 + 5 * i + s);
  endfunction
  task automatic xfer(input logic [4:0] a, input logic wr, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    @(posedge host_bus_clock_i);
    if (bus_style_mux_i) begin
      addr_latch_i <= 1'b1;
      host_data_i <= {3'h0, a};
      {byte_lane1_addr_i, byte_lane0_addr_i} <= a[1:0];
      @(posedge host_bus_clock_i);
      addr_latch_i <= 1'b0;
      addr_data_strobe_n_i <= 1'b0;
    end else begin
      host_addr_i <= a;
      transfer_begin_n_i <= 1'b0;
    end
    host_dir_i <= wr ^ !bus_style_mux_i;
    select_low_in_n_i <= 1'b0;
    select_high_in_i <= 1'b1;
    @(posedge host_bus_clock_i);
    transfer_begin_n_i <= 1'b1;
    addr_data_strobe_n_i <= 1'b1;
    host_data_i <= wd;
    n = 0;
    do begin
      @(posedge host_bus_clock_i);
      #1;
      n++;
    end while (!(transfer_ack_out_oe_o | ready_recover_line_oe_o) && n < 300);
    rd = host_data_o;
    chk(16'({!wr, bus_style_mux_i, !bus_style_mux_i}),
      16'({host_data_oe_o, ready_recover_line_oe_o, transfer_ack_out_oe_o}), "ack");
    chk(16'({a == 5'h04 && wr, a == 5'h04 && !wr, bus_style_mux_i}),
      16'({config_byte_valid_o, readback_take_o, burst_inhibit_out_n_o}), "strobes");
    @(posedge host_bus_clock_i);
    select_low_in_n_i <= 1'b1;
    select_high_in_i <= 1'b0;
  endtask
  task automatic t_map(input logic s);
    logic [7:0] r;
    logic [7:0] e;
    bus_style_mux_i <= s;
    for (int i = 0; i < 16; i++) xfer(5'(i), 1'b1, wv(i, s), r);
    chk({wv(1, s), wv(0, s)}, {control_two_o, control_one_o}, "control");
    chk({wv(6, s), wv(5, s)}, readback_addr_o, "readback address");
    chk(16'(wv(4, s)), 16'(config_byte_o), "config byte");
    for (int i = 0; i < 16; i++) begin
      case (i)
        0, 1, 2: e = wv(i, s);
        3: e = 8'h19;
        4: e = readback_byte_i;
        7, 8, 9, 10: e = ID[8 * (i - 7) +: 8];
        default: e = 8'h00;
      endcase
      if (i != 5 && i != 6) xfer(5'(i), 1'b0, 8'h00, r);
      if (i != 5 && i != 6) chk(16'(e), 16'(r), "register");
    end
  endtask
  task automatic t_user(input logic s);
    logic [7:0] r;
    for (int i = 0; i < 4; i++) begin
      lat <= 4'(i * 3);
      xfer(5'h10 + 5'(i * 5), 1'b1, 8'(8'h3c + i + s), r);
    end
    chk({wv(6, s), wv(5, s)}, readback_addr_o, "readback address");
    for (int i = 0; i < 4; i++) begin
      xfer(5'h10 + 5'(i * 5), 1'b0, 8'h00, r);
      chk(16'(8'h3c + i + s), 16'(r), "user read");
    end
  endtask
  task automatic t_select;
    logic [7:0] r;
    int n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      @(posedge host_bus_clock_i);
      host_addr_i <= 5'h02;
      host_dir_i <= 1'b0;
      select_low_in_n_i <= k[0];
      select_high_in_i <= k[0];
      transfer_begin_n_i <= 1'b0;
      @(posedge host_bus_clock_i);
      transfer_begin_n_i <= 1'b1;
      repeat (8) @(posedge host_bus_clock_i) n += transfer_ack_out_oe_o;
      chk(16'h0, 16'(n), "deselected ack");
    end
    xfer(5'h02, 1'b0, 8'h00, r);
    chk(16'(wv(2, 0)), 16'(r), "scratchpad");
  endtask
  task automatic t_irq;
    logic [7:0] r;
    logic_interrupt_req_n_i <= 1'b0;
    repeat (6) @(posedge host_bus_clock_i);
    chk(16'h1, 16'(host_interrupt_out_oe_o), "interrupt");
    xfer(5'h03, 1'b0, 8'h00, r);
    chk(16'h1b, 16'(r), "status");
    logic_interrupt_req_n_i <= 1'b1;
    repeat (6) @(posedge host_bus_clock_i);
    chk(16'h0, 16'(host_interrupt_out_oe_o), "interrupt");
  endtask
  initial begin
    #1.3;
    forever #3 host_bus_clock_i = ~host_bus_clock_i;
  end
  initial forever #25 sys_clk_i = ~sys_clk_i;
  always @(posedge host_bus_clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge host_bus_clock_i);
    t_map(1'b0);
    t_user(1'b0);
    t_select();
    t_map(1'b1);
    t_user(1'b1);
    t_irq();
    complete_run();
  end
endmodule // hp_host_port_tb
bind hp_host_port hp_host_port_checker u_chk (.*);
